// ---- tb/tacc_conv_ctrl_sva.sv ----
// Port checker for the converter control block.
// Assumes the control register sits at page 1, address 0.
`timescale 1ns/1ps
module tacc_conv_ctrl_chk (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Host port
   input wire [1:0] reg_page,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata,
   // Front end and status
   input wire pen_down_flag,
   input wire adc_power_on,
   input wire adc_start,
   input wire result_available_output
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire ctl = reg_page == 2'h1 && reg_addr == 8'h00;
   wire stop_wr = reg_wr && ctl && reg_wdata[14];
   pen_read_a: assert property (
      reg_rd && ctl |=> reg_rdata[15] == $past(pen_down_flag))
      else $error("pen flag read back wrong");
   status_read_a: assert property (
      reg_rd && ctl |=> reg_rdata[14] == $past(result_available_output)
      && !reg_rdata[0]) else $error("status or reserved bit wrong");
   stop_power_a: assert property (
      stop_wr |=> !adc_power_on) else $error("converter still powered");
   stop_halt_a: assert property (
      stop_wr |=> !adc_start [*8]) else $error("start after stop");
   stop_idle_a: assert property (
      stop_wr |-> ##[1:2] result_available_output)
      else $error("busy after stop");
   start_busy_a: assert property (
      adc_start |-> !result_available_output && adc_power_on)
      else $error("start while idle or off");
   start_pulse_a: assert property (
      adc_start |=> !adc_start) else $error("start longer than a pulse");
   func_zero_a: assert property (
      reg_wr && ctl && reg_wdata[13:10] == 4'h0 && result_available_output
      |=> !adc_start [*8]) else $error("invalid function started");
   host_start_a: assert property (
      reg_wr && ctl && reg_wdata[15:14] == 2'h0 && reg_wdata[13:10] > 4'h2
      && reg_wdata[13:10] < 4'hd && result_available_output
      |-> ##[1:8] adc_start) else $error("host write did not start");
   rdata_hold_a: assert property (
      $changed(reg_rdata) |-> $past(reg_rd) || $past(reg_rd, 2))
      else $error("read data changed without a read");
endmodule
bind tacc_conv_ctrl tacc_conv_ctrl_chk u_chk (.ref_clk, .reset_n, .reg_page,
   .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pen_down_flag,
   .adc_power_on, .adc_start, .result_available_output);

// ---- tb/tacc_conv_ctrl_test.sv ----
// Testbench for the converter control block and its front end model.
// Assumes the host port contract: strobes one cycle, reads answer late.
`timescale 1ns/1ps
module tacc_conv_ctrl_test;
   logic ref_clk = 0;
   logic reset_n = 0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic pen = 0;
   logic [1:0] pg = 0;
   logic [7:0] ad = 0;
   logic [15:0] wd = 0;
   wire [15:0] rdata;
   wire [11:0] smp;
   wire pwr, start, done, rdy;
   wire [1:0] drv;
   wire [3:0] isel;
   logic [15:0] rexp;
   int error_cnt = 0;
   int check_count = 0;
   int starts = 0;
   int s0;
   int cyc = 0;
   int k;
   always #4 ref_clk = ~ref_clk;
   tacc_conv_ctrl uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_page(pg),
      .reg_addr(ad), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(wd),
      .reg_rdata(rdata), .pen_down_flag(pen), .adc_input_sel(isel),
      .adc_power_on(pwr), .panel_drive(drv), .adc_start(start),
      .adc_done(done), .adc_sample(smp), .result_available_output(rdy));
   tacc_fe_model fe (.ref_clk(ref_clk), .reset_n(reset_n), .adc_start(start),
      .adc_power_on(pwr), .adc_done(done), .adc_sample(smp));
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (start === 1'b1) starts <= starts + 1;
      if (cyc == 30000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [1:0] p, logic [7:0] a, logic [15:0] d);
      @(posedge ref_clk);
      #1 pg = p;
      ad = a;
      wd = d;
      reg_wr = 1;
      @(posedge ref_clk);
      #1 reg_wr = 0;
   endtask
   // Waits past the slower result answer; data stands until the next read
   task automatic rd(logic [1:0] p, logic [7:0] a, string n, logic [15:0] e);
      @(posedge ref_clk);
      #1 pg = p;
      ad = a;
      reg_rd = 1;
      @(posedge ref_clk);
      #1 reg_rd = 0;
      repeat (2) @(posedge ref_clk);
      #1 chk(n, e, rdata);
   endtask
   task automatic idle();
      int i;
      repeat (3) @(posedge ref_clk);
      for (i = 0; i < 2000 && rdy !== 1'b1; i++) @(posedge ref_clk);
      #1 chk("idle", 16'h0001, {15'h0, rdy});
   endtask
   task automatic quiet(int n, string s, logic [15:0] e);
      int s1;
      s1 = starts;
      repeat (n) @(posedge ref_clk);
      #1 chk(s, e, 16'(starts > s1));
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      #1 reset_n = 1;
      rd(1, 0, "ctrl reset", 16'h4000);
      pen = 1;
      rd(1, 0, "pen down", 16'hc000);
      pen = 0;
      wr(1, 0, 16'h1800);
      idle();
      rd(0, 8'h06, "bat1 result", 16'h05a7);
      rd(1, 0, "fields", 16'h5800);
      wr(1, 8'h01, 16'hffff);
      rd(1, 0, "unmapped", 16'h5800);
      for (k = 1; k < 4; k++) begin
         s0 = starts;
         wr(1, 0, 16'h1c00 | 16'(k << 6));
         idle();
         chk("avg starts", 16'(1 << (k + 1)), 16'(starts - s0));
         rd(0, 8'h07, "avg result", 16'h05a7);
         wr(1, 0, 16'h1800 | 16'(k << 8));
         idle();
         rexp = (k == 1) ? 16'h05a0 : (k == 2) ? 16'h05a4 : 16'h05a7;
         rd(0, 8'h06, "res result", rexp);
      end
      wr(1, 0, 16'h0800);
      idle();
      rd(0, 8'h03, "scan z2 slot", 16'h05a7);
      wr(1, 0, 16'h2c00);
      idle();
      rd(0, 8'h09, "port scan slot", 16'h05a7);
      pen = 1;
      wr(1, 0, 16'h0400);
      quiet(300, "scan repeats", 16'h0001);
      wr(1, 0, 16'h4500);
      chk("power off", 16'h0000, {15'h0, pwr});
      quiet(60, "halted", 16'h0000);
      rd(1, 0, "stopped", 16'hc500);
      pen = 0;
      wr(1, 0, 16'h8c00);
      quiet(60, "no pen", 16'h0000);
      pen = 1;
      quiet(200, "pen start", 16'h0001);
      pen = 0;
      idle();
      wr(1, 0, 16'h8c02);
      pen = 1;
      quiet(12400, "settling", 16'h0000);
      chk("panel drive", 16'h0001, {14'h0, drv});
      chk("input sel", 16'h0000, {12'h0, isel});
      quiet(300, "settled", 16'h0001);
      pen = 0;
      idle();
      wr(1, 0, 16'h0000);
      quiet(60, "func zero", 16'h0000);
      reset_n = 0;
      repeat (10) @(posedge ref_clk);
      #1 reset_n = 1;
      rd(1, 0, "second reset", 16'h4000);
      chk("power after reset", 16'h0001, {15'h0, pwr});
      complete_run();
   end
endmodule

// ---- tb/tacc_fe_model.sv ----
// Behavioural analog front end: one sample per conversion start.
// Assumes starts are one-cycle pulses from the converter sequencer.
`timescale 1ns/1ps
module tacc_fe_model #(
   parameter int LAT = 3,
   parameter logic [11:0] SAMPLE = 12'h5a7
) (
   input wire ref_clk,
   input wire reset_n,
   input wire adc_start,
   input wire adc_power_on,
   output logic adc_done,
   output logic [11:0] adc_sample
);
   int cnt;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         adc_done <= 1'b0;
         adc_sample <= 12'h000;
      end else begin
         adc_done <= 1'b0;
         // Sample bus is only valid with done; toggle it otherwise
         adc_sample <= ~adc_sample;
         if (!adc_power_on) begin
            cnt <= 0;
         end else if (adc_start) begin
            cnt <= LAT;
         end else if (cnt == 1) begin
            cnt <= 0;
            adc_done <= 1'b1;
            adc_sample <= SAMPLE;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// ---- verilog/tacc_conv_ctrl.v ----
// Touch screen converter control: control register, sequencer and
// result routing. Assumes a simple synchronous host register port
// (page, address, write strobe, read strobe) and an analog front end
// that returns one sample per conversion start.
`timescale 1ns/1ps
`include "tacc_regs.vh"

module tacc_conv_ctrl (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Host register port
   input wire [1:0] reg_page,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   // Touch front end
   input wire pen_down_flag,
   output wire [3:0] adc_input_sel,
   output wire adc_power_on,
   output wire [1:0] panel_drive,
   output wire adc_start,
   input wire adc_done,
   input wire [11:0] adc_sample,
   // Status pin, low while busy
   output wire result_available_output
);
   localparam ST_IDLE = 3'd0;
   localparam ST_SETTLE = 3'd1;
   localparam ST_START = 3'd2;
   localparam ST_WAIT = 3'd3;
   localparam ST_NEXT = 3'd4;

   reg pen_state_mode_bit_q;
   reg [3:0] function_select_q;
   reg [1:0] resolution_select_q;
   reg [1:0] averaging_select_q;
   reg [1:0] clock_select_q;
   reg [2:0] settle_time_select_q;
   reg run_q;
   reg [2:0] state_q;
   reg [23:0] settle_q;
   reg [4:0] avg_cnt_q;
   reg [15:0] acc_q;
   reg [1:0] step_q;
   reg [15:0] result_q;
   reg [3:0] res_addr_q;
   reg wr_res_q;
   reg rd_res_q;
   // Host mode starts once per valid write; idle would otherwise restart
   reg req_q;
   wire [15:0] mem_rdata;
   wire ctrl_sel;
   wire busy;
   wire [15:0] avg_val;
   reg [23:0] settle_cycles;
   reg [4:0] avg_total;
   reg [3:0] avg_shift;
   reg [1:0] last_step;
   reg [3:0] slot;
   reg [3:0] in_sel;
   reg [11:0] masked;

   assign ctrl_sel = (reg_page == `TACC_PAGE_CTRL) &&
      (reg_addr == `TACC_CTRL_ADDR);
   assign busy = (state_q != ST_IDLE);
   assign result_available_output = ~busy;
   assign adc_power_on = run_q;
   assign adc_start = (state_q == ST_START);
   assign adc_input_sel = in_sel;
   assign avg_val = acc_q >> avg_shift;
   assign panel_drive = (busy && function_select_q <= 4'h5) ?
      ((in_sel[0]) ? 2'h2 : 2'h1) : 2'h0;

   // Settle time by code
   always @* begin
      case (settle_time_select_q)
         3'd1: settle_cycles = `TACC_CYC(`TACC_T1_US);
         3'd2: settle_cycles = `TACC_CYC(`TACC_T2_US);
         3'd3: settle_cycles = `TACC_CYC(`TACC_T3_US);
         3'd4: settle_cycles = `TACC_CYC(`TACC_T4_US);
         3'd5: settle_cycles = `TACC_CYC(`TACC_T5_US);
         3'd6: settle_cycles = `TACC_CYC(`TACC_T6_US);
         3'd7: settle_cycles = `TACC_CYC(`TACC_T7_US);
         default: settle_cycles = 24'h000000;
      endcase
   end

   // Samples per average and the divide shift
   always @* begin
      case (averaging_select_q)
         2'h1: begin avg_total = 5'd4; avg_shift = 4'd2; end
         2'h2: begin avg_total = 5'd8; avg_shift = 4'd3; end
         2'h3: begin avg_total = 5'd16; avg_shift = 4'd4; end
         default: begin avg_total = 5'd1; avg_shift = 4'd0; end
      endcase
   end

   // Steps and slots per function; slot numbers match page-0 order
   always @* begin
      last_step = 2'd0;
      slot = function_select_q;
      in_sel = function_select_q;
      case (function_select_q)
         4'h1: begin
            last_step = 2'd1;
            slot = {2'b00, step_q};
            in_sel = {2'b00, step_q};
         end
         4'h2: begin
            last_step = 2'd3;
            slot = {2'b00, step_q};
            in_sel = {2'b00, step_q};
         end
         4'h3: begin slot = 4'h0; in_sel = 4'h0; end
         4'h4: begin slot = 4'h1; in_sel = 4'h1; end
         4'h5: begin
            last_step = 2'd1;
            slot = {3'b001, step_q[0]};
            in_sel = slot;
         end
         4'hb: begin
            last_step = 2'd3;
            slot = {2'b01, step_q} + 4'h2;
            in_sel = slot;
         end
         default: begin
            slot = function_select_q;
            in_sel = function_select_q;
         end
      endcase
   end

   // Resolution truncation of the averaged sample
   always @* begin
      masked = avg_val[11:0];
      case (resolution_select_q)
         `TACC_RES_8: masked = {avg_val[11:4], 4'h0};
         `TACC_RES_10: masked = {avg_val[11:2], 2'h0};
         default: masked = avg_val[11:0];
      endcase
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pen_state_mode_bit_q <= 1'b0;
         function_select_q <= `TACC_FUNC_NONE;
         resolution_select_q <= `TACC_RES_12A;
         averaging_select_q <= 2'h0;
         clock_select_q <= 2'h0;
         settle_time_select_q <= 3'h0;
         run_q <= 1'b1;
         state_q <= ST_IDLE;
         settle_q <= 24'h0;
         avg_cnt_q <= 5'h0;
         acc_q <= 16'h0;
         step_q <= 2'h0;
         result_q <= 16'h0;
         res_addr_q <= 4'h0;
         wr_res_q <= 1'b0;
         reg_rdata <= 16'h0;
         rd_res_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         wr_res_q <= 1'b0;
         rd_res_q <= reg_rd && (reg_page == `TACC_PAGE_RES);
         if (reg_rd && ctrl_sel) begin
            reg_rdata <= {pen_down_flag, ~busy, function_select_q,
               resolution_select_q, averaging_select_q, clock_select_q,
               settle_time_select_q, 1'b0};
         end else if (rd_res_q) begin
            reg_rdata <= mem_rdata;
         end
         case (state_q)
            ST_IDLE: begin
               step_q <= 2'h0;
               avg_cnt_q <= 5'h0;
               acc_q <= 16'h0;
               if (run_q && function_select_q != `TACC_FUNC_NONE &&
                  function_select_q < 4'hd &&
                  (pen_state_mode_bit_q ? pen_down_flag : req_q)) begin
                  state_q <= ST_SETTLE;
                  req_q <= 1'b0;
                  settle_q <= pen_state_mode_bit_q ?
                     settle_cycles : 24'h0;
               end
            end
            ST_SETTLE: begin
               // A lifted pen cancels a self-driven run before sampling
               if (pen_state_mode_bit_q && !pen_down_flag) begin
                  state_q <= ST_IDLE;
               end else if (settle_q == 24'h0) begin
                  state_q <= ST_START;
               end else begin
                  settle_q <= settle_q - 24'h1;
               end
            end
            ST_START: state_q <= ST_WAIT;
            ST_WAIT: begin
               if (adc_done) begin
                  acc_q <= acc_q + {4'h0, adc_sample};
                  avg_cnt_q <= avg_cnt_q + 5'h1;
                  state_q <= (avg_cnt_q + 5'h1 == avg_total) ?
                     ST_NEXT : ST_START;
               end
            end
            ST_NEXT: begin
               acc_q <= 16'h0;
               avg_cnt_q <= 5'h0;
               wr_res_q <= 1'b1;
               res_addr_q <= slot;
               result_q <= {4'h0, masked};
               if (step_q != last_step) begin
                  step_q <= step_q + 2'h1;
                  state_q <= ST_START;
               end else if (function_select_q <= 4'h2 &&
                  pen_down_flag) begin
                  step_q <= 2'h0;
                  state_q <= ST_SETTLE;
                  settle_q <= 24'h0;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         if (reg_wr && ctrl_sel) begin
            pen_state_mode_bit_q <= reg_wdata[`TACC_MODE_BIT];
            function_select_q <= reg_wdata[`TACC_FUNC_HI:`TACC_FUNC_LO];
            resolution_select_q <= reg_wdata[`TACC_RES_HI:`TACC_RES_LO];
            averaging_select_q <= reg_wdata[`TACC_AVG_HI:`TACC_AVG_LO];
            clock_select_q <= reg_wdata[`TACC_CLK_HI:`TACC_CLK_LO];
            settle_time_select_q <= reg_wdata[`TACC_SET_HI:`TACC_SET_LO];
            run_q <= ~reg_wdata[`TACC_STAT_BIT];
            req_q <= ~reg_wdata[`TACC_STAT_BIT];
            if (reg_wdata[`TACC_STAT_BIT] ||
               (reg_wdata[`TACC_FUNC_HI:`TACC_FUNC_LO] ==
               `TACC_FUNC_NONE)) begin
               state_q <= ST_IDLE;
               wr_res_q <= 1'b0;
            end
         end
      end
   end

   // Results arrive already cut to the selected resolution
   tacc_result_mem u_mem (
      .ref_clk(ref_clk),
      .wr_en(wr_res_q && function_select_q != `TACC_FUNC_NONE),
      .wr_addr(res_addr_q),
      .wr_data(result_q),
      .rd_addr(reg_addr[3:0]),
      .rd_data(mem_rdata)
   );
endmodule

// ---- verilog/tacc_regs.vh ----
// Constants for the touch converter control block: register map,
// field positions, reset values and settle timing counts.
// Assumes a 125 MHz ref_clk; included by the control block only.
`ifndef TACC_REGS_VH
`define TACC_REGS_VH

`define TACC_CTRL_ADDR 8'h00
`define TACC_PAGE_CTRL 2'h1
`define TACC_PAGE_RES 2'h0

`define TACC_MODE_BIT 15
`define TACC_STAT_BIT 14
`define TACC_FUNC_HI 13
`define TACC_FUNC_LO 10
`define TACC_RES_HI 9
`define TACC_RES_LO 8
`define TACC_AVG_HI 7
`define TACC_AVG_LO 6
`define TACC_CLK_HI 5
`define TACC_CLK_LO 4
`define TACC_SET_HI 3
`define TACC_SET_LO 1

`define TACC_FUNC_NONE 4'h0
`define TACC_RES_12A 2'h0
`define TACC_RES_8 2'h1
`define TACC_RES_10 2'h2

// Settle times in microseconds, then in ref_clk cycles; 24 bits hold
// the longest product without any cut
`define TACC_CLK_MHZ 24'h00007d
`define TACC_T1_US 24'h000064
`define TACC_T2_US 24'h0001f4
`define TACC_T3_US 24'h0003e8
`define TACC_T4_US 24'h001388
`define TACC_T5_US 24'h002710
`define TACC_T6_US 24'h00c350
`define TACC_T7_US 24'h0186a0
`define TACC_CYC(us) ((us) * `TACC_CLK_MHZ)

// Cycles of one simulated conversion, per conversion clock code
`define TACC_CONV_BASE 24'h000010

`endif

// ---- verilog/tacc_result_mem.v ----
// Result memory: one 16-bit word per page-0 result slot.
// Written by the converter sequencer, read by the host port.
`timescale 1ns/1ps
module tacc_result_mem (
   // Clock
   input wire ref_clk,
   // Write side
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [15:0] wr_data,
   // Read side, registered
   input wire [3:0] rd_addr,
   output reg [15:0] rd_data
);
   reg [15:0] mem [0:15];

   always @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
